// ### hw/card_cmd_defs.vh
// Register offsets, opcodes, sense codes and constants of the card command core
`ifndef CARD_CMD_DEFS_VH
`define CARD_CMD_DEFS_VH
`define CLK_KHZ 100000
`define A_CMD 6'h00
`define A_FEAT 6'h04
`define A_CNT 6'h08
`define A_SEC 6'h0C
`define A_STAT 6'h10
`define A_DATA 6'h14
`define A_SENSE 6'h18
`define A_MODE 6'h1C
`define A_CTRL 6'h20
`define C_SRST 0
`define C_ABORT 1
`define OP_SENSE 8'h03
`define OP_SEEK 4'h7
`define OP_SETF 8'hEF
`define OP_SETMUL 8'hC6
`define OP_SLP 8'hE6
`define OP_SLP2 8'h99
`define OP_STB 8'hE2
`define OP_STB2 8'h96
`define OP_STBI 8'hE0
`define OP_STBI2 8'h94
`define OP_XLAT 8'h87
`define OP_WEAR 8'hF5
`define OP_WRBUF 8'hE8
`define OP_RDBUF 8'hE4
`define OP_WRL 8'h32
`define OP_WRL2 8'h33
`define OP_WRM 8'hC5
`define OP_WRMNE 8'hCD
`define OP_WRNE 8'h38
`define OP_WR 8'h30
`define OP_WR2 8'h31
`define OP_WRV 8'h3C
`define OP_RD 8'h20
`define OP_RD2 8'h21
`define OP_RDL 8'h22
`define OP_RDL2 8'h23
`define OP_RDM 8'hC4
`define F_X8_ON 8'h01
`define F_X8_OFF 8'h81
`define F_NOLA 8'h55
`define F_ECC4 8'hBB
`define F_KEEP 8'h66
`define F_NOKEEP 8'hCC
`define E_NONE 8'h00
`define E_SELF 8'h01
`define E_INV 8'h20
`define E_ADDR 8'h21
`define E_OVF 8'h2F
`define E_ECC 8'h11
`define E_SPARE 8'h3A
`define E_XFER 8'h1F
`define E_PWR1 8'h22
`define E_SUPPLY 8'h35
`define M_RD 2'h1
`define M_WR 2'h2
`define M_VFY 2'h3
`define SEC_LEN 10'd512
`define SEC_LEN_LONG 10'd516
`define BUF_BYTES 516
`define SEC_256 9'd256
`endif

// ### hw/ata_card_command_set.v
// Command interpreter of the flash card task file, Avalon-MM slave
// Operation
// [RULE1] Sense opcode 03h returns last extended error code: 00,01,20,21.
// [RULE2] Further sense codes: 2F overflow, 11 ECC, 3A spares, 1F abort, 22, 35.
// [RULE3] Seek 7Xh does no media work, only range checks the address.
// [RULE4] Feature EFh: 01h selects 8-bit transfers, 81h restores 16-bit.
// [RULE5] Feature 55h disables look-ahead; BBh selects four ECC bytes on long.
// [RULE6] Feature 66h keeps settings over soft reset; CCh restores reload.
// [RULE7] C6h enables multiple mode and stores the block count.
// [RULE8] E6h/99h: interrupt, sleep; only hard or soft reset wakes.
// [RULE9] E2h/96h: standby; nonzero count arms auto power down timer.
// [RULE10] E0h/94h: enter standby and interrupt at once.
// [RULE11] Opcode 87h is unsupported and aborted.
// [RULE12] F5h does nothing and returns sector count 00h.
// [RULE13] E8h fills the sector buffer from host, no media write.
// [RULE14] 32h/33h write like normal but 516 bytes per sector.
// [RULE15] C5h writes with one interrupt per block of set count.
// [RULE16] CDh multiple write without erase; host erased beforehand.
// [RULE17] 38h write without erase; host erased beforehand.
// [RULE18] 30h/31h write 1..256 sectors from sector number, zero is 256.
// [RULE19] 3Ch verifies each sector after programming, error on failure.
// [RULE20] 20h/21h read 1..256 sectors from sector number, zero is 256.
// [RULE21] Unknown opcodes abort with error and invalid-command sense code.
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "card_cmd_defs.vh"
module ata_card_command_set #(
   parameter LBA_W = 28,
   parameter [27:0] MAX_LBA = 28'h0020000,
   parameter APD_UNIT_MS = 5000
) (
   input wire clock_i,
   input wire srst_i,
   input wire ce_i,
   input wire [5:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   output reg intrq_o,
   output reg media_req_o,
   output reg [1:0] media_op_o,
   output reg media_noerase_o,
   output reg [LBA_W-1:0] media_lba_o,
   input wire media_done_i,
   input wire media_fail_i,
   input wire [9:0] media_idx_i,
   input wire media_we_i,
   input wire [7:0] media_wdata_i,
   output reg [7:0] media_rdata_o,
   input wire supply_fault_i
);
   localparam S_IDLE = 7'h01;
   localparam S_IN = 7'h02;
   localparam S_PROG = 7'h04;
   localparam S_VFY = 7'h08;
   localparam S_FETCH = 7'h10;
   localparam S_OUT = 7'h20;
   localparam S_SLEEP = 7'h40;
   localparam [31:0] APD_TICK = APD_UNIT_MS * `CLK_KHZ;

   reg [6:0] st_q;
   reg err_q, stby_q, apd_q;
   reg x8_q, nola_q, ecc4_q, keep_q, mul_q;
   reg [7:0] blk_q, feat_q, cnt_q, cmd_q, last_q, sense_q;
   reg [7:0] bpos_q, apd_ld_q, apd_cnt_q;
   reg [LBA_W-1:0] sec_q;
   reg [9:0] bc_q;
   reg [8:0] left_q;
   reg long_q, mblk_q, vfy_q, bufo_q;
   reg [31:0] pre_q;
   reg [7:0] buf_q [0:`BUF_BYTES-1];

   wire take = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
   wire wr = take & avs_write_i;
   wire [7:0] d8 = avs_writedata_i[7:0];
   wire [9:0] len = long_q ? `SEC_LEN_LONG : `SEC_LEN;
   wire [9:0] step = x8_q ? 10'd1 : 10'd2;
   wire [9:0] bc_n = bc_q + step;
   wire sec_end = bc_n >= len;
   wire [LBA_W-1:0] sec_n = media_lba_o + 1'b1;
   wire blk_end = ~mblk_q | (bpos_q == 8'd1);
   wire blk_start = ~mblk_q | (bpos_q == blk_q);
   wire busy = |(st_q & (S_PROG | S_VFY | S_FETCH));
   wire drq = |(st_q & (S_IN | S_OUT));
   wire in_range = sec_q < MAX_LBA;

   // Ends a command; event flags set here win over a same-cycle status-read clear, but a same-cycle soft reset clears them
   task finish;
      input [7:0] code;
      input irq;
      begin
         st_q <= S_IDLE;
         media_req_o <= 1'b0;
         err_q <= code != `E_NONE;
         last_q <= code;
         if (irq)
            intrq_o <= 1'b1;
         apd_cnt_q <= apd_ld_q;
         pre_q <= 32'h0;
      end
   endtask

   task start;
      input lng;
      input mb;
      input vf;
      input ne;
      input rd;
      begin
         long_q <= lng;
         mblk_q <= mb;
         vfy_q <= vf;
         media_noerase_o <= ne;
         if (!in_range)
            finish(`E_ADDR, 1'b1);
         else if (rd)
            st_q <= S_FETCH;
         else
            st_q <= S_IN;
      end
   endtask

   // Advance to the next sector, or end the command
   task next;
      input rd;
      begin
         bc_q <= 10'h0;
         if (left_q == 9'd1 || bufo_q) begin
            finish(`E_NONE, ~rd);
         end else if (sec_n >= MAX_LBA) begin
            finish(`E_OVF, 1'b1); // [RULE2]
         end else begin
            media_lba_o <= sec_n;
            left_q <= left_q - 9'd1;
            bpos_q <= blk_end ? blk_q : bpos_q - 8'd1;
            if (blk_end && !rd)
               intrq_o <= 1'b1; // [RULE15]
            st_q <= rd ? S_FETCH : S_IN;
         end
      end
   endtask

   task defaults;
      begin
         x8_q <= 1'b0;
         nola_q <= 1'b0;
         ecc4_q <= 1'b0;
         mul_q <= 1'b0;
         blk_q <= 8'h0;
      end
   endtask

   always @(posedge clock_i) begin
      if (srst_i) begin
         st_q <= S_IDLE;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0;
         intrq_o <= 1'b0;
         media_req_o <= 1'b0;
         media_op_o <= 2'h0;
         media_noerase_o <= 1'b0;
         media_lba_o <= {LBA_W{1'b0}};
         media_rdata_o <= 8'h0;
         err_q <= 1'b0;
         stby_q <= 1'b0;
         apd_q <= 1'b0;
         keep_q <= 1'b0;
         defaults;
         feat_q <= 8'h0;
         cnt_q <= 8'h0;
         cmd_q <= 8'h0;
         last_q <= `E_SELF;
         sense_q <= 8'h0;
         bpos_q <= 8'h0;
         apd_ld_q <= 8'h0;
         apd_cnt_q <= 8'h0;
         sec_q <= {LBA_W{1'b0}};
         bc_q <= 10'h0;
         left_q <= 9'h0;
         long_q <= 1'b0;
         mblk_q <= 1'b0;
         vfy_q <= 1'b0;
         bufo_q <= 1'b0;
         pre_q <= 32'h0;
      end else if (ce_i) begin
         media_rdata_o <= buf_q[media_idx_i];
         if (st_q == S_FETCH && media_we_i)
            buf_q[media_idx_i] <= media_wdata_i;
         // One wait state: read data are prepared, effects act next edge
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
         if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
            case (avs_address_i)
               `A_CMD: avs_readdata_o <= {24'h0, cmd_q};
               `A_FEAT: avs_readdata_o <= {24'h0, feat_q};
               `A_CNT: avs_readdata_o <= {24'h0, cnt_q};
               `A_SEC: avs_readdata_o <= {{(32-LBA_W){1'b0}}, sec_q};
               `A_STAT: avs_readdata_o <= {24'h0, 1'b0, apd_q, stby_q,
                  st_q == S_SLEEP, intrq_o, err_q, drq, busy};
               `A_DATA: avs_readdata_o <= {16'h0,
                  x8_q ? 8'h0 : buf_q[bc_q + 10'd1], buf_q[bc_q]};
               `A_SENSE: avs_readdata_o <= {24'h0, sense_q};
               `A_MODE: avs_readdata_o <= {16'h0, blk_q, 3'h0,
                  mul_q, keep_q, ecc4_q, nola_q, x8_q};
               default: avs_readdata_o <= 32'h0;
            endcase
         end
         if (take && avs_read_i && avs_address_i == `A_STAT)
            intrq_o <= 1'b0;
         // Auto power down countdown runs only while idle
         if (apd_q && st_q == S_IDLE && !stby_q) begin
            if (pre_q == APD_TICK - 32'd1) begin
               pre_q <= 32'h0;
               if (apd_cnt_q <= 8'd1)
                  stby_q <= 1'b1; // [RULE9]
               else
                  apd_cnt_q <= apd_cnt_q - 8'd1;
            end else begin
               pre_q <= pre_q + 32'd1;
            end
         end
         // Media request rises one cycle after entering a media state
         if (busy) begin
            if (!media_req_o) begin
               media_req_o <= 1'b1;
               media_op_o <= st_q == S_FETCH ? `M_RD :
                  st_q == S_VFY ? `M_VFY : `M_WR;
            end else if (media_done_i) begin
               media_req_o <= 1'b0;
               case (st_q)
                  S_PROG: begin
                     if (media_fail_i)
                        finish(`E_SPARE, 1'b1);
                     else if (vfy_q)
                        st_q <= S_VFY; // [RULE19]
                     else
                        next(1'b0);
                  end
                  S_VFY: begin
                     if (media_fail_i)
                        finish(`E_ECC, 1'b1); // [RULE19]
                     else
                        next(1'b0);
                  end
                  default: begin
                     if (media_fail_i) begin
                        finish(`E_ECC, 1'b1); // [RULE2]
                     end else begin
                        st_q <= S_OUT;
                        if (blk_start)
                           intrq_o <= 1'b1;
                     end
                  end
               endcase
            end
         end
         if (wr && avs_address_i == `A_FEAT)
            feat_q <= d8;
         if (wr && avs_address_i == `A_CNT && st_q == S_IDLE)
            cnt_q <= d8;
         if (wr && avs_address_i == `A_SEC && st_q == S_IDLE)
            sec_q <= avs_writedata_i[LBA_W-1:0];
         // Host data into the sector buffer
         if (wr && avs_address_i == `A_DATA && st_q == S_IN) begin
            buf_q[bc_q] <= d8;
            if (!x8_q)
               buf_q[bc_q + 10'd1] <= avs_writedata_i[15:8]; // [RULE4]
            bc_q <= bc_n;
            if (sec_end) begin
               if (bufo_q)
                  finish(`E_NONE, 1'b1); // [RULE13]
               else
                  st_q <= S_PROG;
            end
         end
         if (take && avs_read_i && avs_address_i == `A_DATA && st_q == S_OUT) begin
            bc_q <= bc_n;
            if (sec_end)
               next(1'b1);
         end
         // Commands are ignored while busy, transferring or asleep
         if (wr && avs_address_i == `A_CMD && st_q == S_IDLE) begin
            cmd_q <= d8;
            stby_q <= 1'b0;
            bc_q <= 10'h0;
            bufo_q <= 1'b0;
            media_lba_o <= sec_q;
            left_q <= cnt_q == 8'h0 ? `SEC_256 : {1'b0, cnt_q}; // [RULE18] [RULE20]
            bpos_q <= blk_q;
            long_q <= 1'b0;
            if (supply_fault_i) begin
               finish(`E_SUPPLY, 1'b1); // [RULE2]
            end else begin
               case (d8)
                  `OP_SENSE: begin
                     sense_q <= last_q; // [RULE1]
                     finish(`E_NONE, 1'b1);
                  end
                  `OP_SETF: begin
                     finish(`E_NONE, 1'b1);
                     case (feat_q)
                        `F_X8_ON: x8_q <= 1'b1; // [RULE4]
                        `F_X8_OFF: x8_q <= 1'b0; // [RULE4]
                        `F_NOLA: nola_q <= 1'b1; // [RULE5]
                        `F_ECC4: ecc4_q <= 1'b1; // [RULE5]
                        `F_KEEP: keep_q <= 1'b1; // [RULE6]
                        `F_NOKEEP: keep_q <= 1'b0; // [RULE6]
                        default: finish(`E_INV, 1'b1);
                     endcase
                  end
                  `OP_SETMUL: begin
                     mul_q <= cnt_q != 8'h0; // [RULE7]
                     blk_q <= cnt_q; // [RULE7]
                     finish(`E_NONE, 1'b1);
                  end
                  `OP_SLP, `OP_SLP2: begin
                     finish(`E_NONE, 1'b1);
                     st_q <= S_SLEEP; // [RULE8]
                  end
                  `OP_STB, `OP_STB2: begin
                     finish(`E_NONE, 1'b1);
                     stby_q <= 1'b1; // [RULE9]
                     apd_q <= cnt_q != 8'h0; // [RULE9]
                     apd_ld_q <= cnt_q;
                     apd_cnt_q <= cnt_q;
                  end
                  `OP_STBI, `OP_STBI2: begin
                     finish(`E_NONE, 1'b1);
                     stby_q <= 1'b1; // [RULE10]
                  end
                  `OP_XLAT: finish(`E_INV, 1'b1); // [RULE11]
                  `OP_WEAR: begin
                     cnt_q <= 8'h0; // [RULE12]
                     finish(`E_NONE, 1'b1);
                  end
                  `OP_WRBUF: begin
                     bufo_q <= 1'b1; // [RULE13]
                     st_q <= S_IN;
                  end
                  `OP_RDBUF: begin
                     bufo_q <= 1'b1;
                     st_q <= S_OUT;
                     intrq_o <= 1'b1;
                  end
                  `OP_WRL, `OP_WRL2: start(1'b1, 1'b0, 1'b0, 1'b0, 1'b0); // [RULE14]
                  `OP_WR, `OP_WR2: start(1'b0, 1'b0, 1'b0, 1'b0, 1'b0); // [RULE18]
                  `OP_WRNE: start(1'b0, 1'b0, 1'b0, 1'b1, 1'b0); // [RULE17]
                  `OP_WRV: start(1'b0, 1'b0, 1'b1, 1'b0, 1'b0); // [RULE19]
                  `OP_RD, `OP_RD2: start(1'b0, 1'b0, 1'b0, 1'b0, 1'b1); // [RULE20]
                  `OP_RDL, `OP_RDL2: start(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
                  `OP_WRM, `OP_WRMNE, `OP_RDM: begin
                     // Multiple transfers need a prior block count
                     if (!mul_q)
                        finish(`E_INV, 1'b1);
                     else
                        start(1'b0, 1'b1, 1'b0, d8 == `OP_WRMNE, d8 == `OP_RDM); // [RULE15] [RULE16]
                  end
                  default: begin
                     if (d8[7:4] == `OP_SEEK)
                        finish(in_range ? `E_NONE : `E_ADDR, 1'b1); // [RULE3]
                     else
                        finish(`E_INV, 1'b1); // [RULE21]
                  end
               endcase
            end
         end
         if (wr && avs_address_i == `A_CTRL) begin
            if (avs_writedata_i[`C_ABORT] && drq)
               finish(`E_XFER, 1'b1); // [RULE2]
            // Soft reset outranks all; the only exit from sleep besides srst_i
            if (avs_writedata_i[`C_SRST]) begin
               st_q <= S_IDLE; // [RULE8]
               media_req_o <= 1'b0;
               stby_q <= 1'b0;
               err_q <= 1'b0;
               intrq_o <= 1'b0;
               last_q <= `E_SELF;
               if (!keep_q)
                  defaults; // [RULE6]
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/ata_card_command_set_properties.sv
// Handshake assertions of the card command core, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module ata_card_command_set_properties #(parameter LBA_W = 28) (
   input wire clock_i,
   input wire srst_i,
   input wire ce_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire avs_waitrequest_o,
   input wire intrq_o,
   input wire media_req_o,
   input wire [1:0] media_op_o,
   input wire [LBA_W-1:0] media_lba_o,
   input wire media_done_i
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   wire bus_req = avs_read_i | avs_write_i;
   chk_wait_taken: assert property (bus_req && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
      else $error("access not answered after one wait cycle");
   chk_wait_single: assert property (!avs_waitrequest_o && ce_i |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   chk_wait_idle: assert property (!bus_req && avs_waitrequest_o && ce_i |=> avs_waitrequest_o)
      else $error("waitrequest dropped without a request");
   // Abort and soft reset arrive as writes, so writes are excluded
   chk_req_held: assert property (media_req_o && !media_done_i && !avs_write_i |=> media_req_o)
      else $error("media request dropped before done");
   chk_req_release: assert property (media_req_o && media_done_i |=> !media_req_o)
      else $error("media request held after done");
   chk_op_valid: assert property (media_req_o |-> media_op_o != 2'h0)
      else $error("media request without operation");
   chk_lba_steady: assert property (media_req_o && $past(media_req_o) |-> $stable(media_lba_o))
      else $error("media address moved during request");
   chk_irq_pending: assert property (intrq_o && !bus_req |=> intrq_o)
      else $error("interrupt lost without host access");
   chk_verify_after: assert property ($rose(media_req_o) && media_op_o == 2'h3 |-> $past(media_op_o, 2) == 2'h2)
      else $error("verify not preceded by program");
endmodule
bind ata_card_command_set ata_card_command_set_properties #(.LBA_W(LBA_W)) props (
   .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .intrq_o(intrq_o),
   .media_req_o(media_req_o), .media_op_o(media_op_o), .media_lba_o(media_lba_o),
   .media_done_i(media_done_i));
`default_nettype wire

// ### tb/media_model.sv
// Media engine model: fills the buffer on reads, answers every request with done
`timescale 1ns/10ps
`default_nettype none
module media_model (
   input wire logic clock_i,
   input wire logic req_i,
   input wire logic [1:0] op_i,
   input wire logic [1:0] fail_op_i,
   output logic done_o = 1'b0,
   output logic fail_o = 1'b0,
   output logic we_o = 1'b0,
   output logic [9:0] idx_o = 10'h000,
   output logic [7:0] wdata_o = 8'h00
);
   int n = 0;
   always @(posedge clock_i) begin
      done_o <= 1'b0;
      we_o <= 1'b0;
      // Fail flag carries no meaning outside done, so it toggles
      fail_o <= ~fail_o;
      if (!req_i) begin
         n <= 0;
      end else if (!done_o) begin
         n <= n + 1;
         if (op_i == 2'h1 && n < 512) begin
            we_o <= 1'b1;
            idx_o <= n[9:0];
            wdata_o <= n[7:0] ^ 8'hA5;
         end else if (n >= (op_i == 2'h1 ? 512 : 6)) begin
            done_o <= 1'b1;
            fail_o <= (op_i == fail_op_i);
            n <= 0;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/ata_card_command_set_test.sv
// Self-checking bench of the card command core with a media engine model
`timescale 1ns/10ps
`default_nettype none
`include "card_cmd_defs.vh"
module ata_card_command_set_test;
   localparam logic [27:0] LAST = 28'h0000100;
   logic clock_i = 0, srst_i = 1, rd_q = 0, wr_q = 0, supply = 0, req_d = 0, irq_d = 0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdat = 32'h0, rdata, got;
   logic waitr, intrq, req, noer, done, fail, we, last_ne;
   logic [1:0] op, fail_op = 2'h0;
   logic [27:0] lba, last_lba;
   logic [9:0] idx;
   logic [7:0] wd, ops = 8'h00;
   logic [7:0] mrd;
   logic [15:0] wbuf [256];
   int num_errors = 0, checks = 0, reqs = 0, irqs = 0;
   always #5 clock_i = ~clock_i;
   ata_card_command_set #(.MAX_LBA(LAST), .APD_UNIT_MS(1)) dut (.clock_i(clock_i),
      .srst_i(srst_i), .ce_i(1'b1), .avs_address_i(addr), .avs_read_i(rd_q),
      .avs_write_i(wr_q), .avs_writedata_i(wdat), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitr), .intrq_o(intrq), .media_req_o(req), .media_op_o(op),
      .media_noerase_o(noer), .media_lba_o(lba), .media_done_i(done), .media_fail_i(fail),
      .media_idx_i(idx), .media_we_i(we), .media_wdata_i(wd), .media_rdata_o(mrd),
      .supply_fault_i(supply));
   media_model media (.clock_i(clock_i), .req_i(req), .op_i(op), .fail_op_i(fail_op),
      .done_o(done), .fail_o(fail), .we_o(we), .idx_o(idx), .wdata_o(wd));
   always @(posedge clock_i) begin
      req_d <= req;
      irq_d <= intrq;
      if (intrq && !irq_d) irqs++;
      if (req && !req_d) begin
         reqs++;
         ops <= {ops[5:0], op};
         last_lba <= lba;
         last_ne <= noer;
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int t = 0;
      @(posedge clock_i);
      addr <= a;
      wdat <= d;
      wr_q <= w;
      rd_q <= !w;
      do begin
         @(posedge clock_i);
         t++;
      end while (waitr !== 1'b0 && t < 40);
      got = rdata;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      if (t >= 40) chk("waitrequest", waitr, 0);
   endtask
   task automatic cmd(input logic [7:0] o);
      bus(1, `A_CMD, {24'h0, o});
   endtask
   task automatic regs(input logic [7:0] c, input logic [27:0] s);
      bus(1, `A_CNT, {24'h0, c});
      bus(1, `A_SEC, {4'h0, s});
   endtask
   task automatic wait_st(input logic [1:0] e);
      int t = 0;
      do begin
         bus(0, `A_STAT, 0);
         t++;
      end while (got[1:0] !== e && t < 3000);
      chk("status", got[1:0], e);
   endtask
   task automatic sense(input logic [7:0] e);
      cmd(`OP_SENSE);
      bus(0, `A_SENSE, 0);
      chk("sense", got[7:0], e);
   endtask
   task automatic wsec(input logic [7:0] o, c, input logic [27:0] s, input int ns, nw);
      regs(c, s);
      cmd(o);
      repeat (ns) begin
         wait_st(2'b10);
         for (int i = 0; i < nw; i++) bus(1, `A_DATA, 32'(i));
      end
      wait_st(2'b00);
   endtask
   task automatic rsec(input logic [7:0] o, input logic [27:0] s);
      regs(1, s);
      cmd(o);
      wait_st(2'b10);
      for (int i = 0; i < 256; i++) begin
         bus(0, `A_DATA, 0);
         wbuf[i] = got[15:0];
      end
      wait_st(2'b00);
   endtask
   task automatic feat(input logic [7:0] f, input logic [3:0] e, input logic rst);
      if (f != 8'h00) bus(1, `A_FEAT, {24'h0, f});
      if (f != 8'h00) cmd(`OP_SETF);
      if (rst) bus(1, `A_CTRL, 1);
      bus(0, `A_MODE, 0);
      chk("mode", got[3:0], e);
   endtask
   task automatic t_sense;
      bus(1, `A_CTRL, 1);
      sense(`E_SELF);
      sense(`E_NONE);
      cmd(`OP_XLAT);
      bus(0, `A_STAT, 0);
      chk("abort err", got[2], 1);
      sense(`E_INV);
      cmd(8'h5A);
      sense(`E_INV);
      supply <= 1'b1;
      cmd(`OP_WEAR);
      supply <= 1'b0;
      sense(`E_SUPPLY);
      feat(`F_X8_ON, 4'h1, 0);
      feat(`F_NOLA, 4'h3, 0);
      feat(`F_ECC4, 4'h7, 0);
      feat(`F_KEEP, 4'hF, 0);
      feat(`F_X8_OFF, 4'hE, 1);
      feat(`F_NOKEEP, 4'h0, 1);
      $display("sense and feature test done");
   endtask
   task automatic t_power;
      int n;
      regs(8'h2, 0);
      cmd(`OP_STB);
      bus(0, `A_STAT, 0);
      chk("standby apd", got[6:5], 2'b11);
      regs(8'h0, 0);
      cmd(`OP_STB);
      bus(0, `A_STAT, 0);
      chk("standby no apd", got[6:5], 2'b01);
      cmd(`OP_STBI);
      @(negedge clock_i);
      chk("standby irq", intrq, 1);
      bus(0, `A_STAT, 0);
      chk("standby", got[5], 1);
      cmd(`OP_SLP);
      @(negedge clock_i);
      chk("sleep irq", intrq, 1);
      cmd(`OP_STBI);
      bus(0, `A_STAT, 0);
      chk("asleep", got[4], 1);
      bus(1, `A_CTRL, 1);
      bus(0, `A_STAT, 0);
      chk("awake", got[4], 0);
      regs(8'h5, 0);
      cmd(`OP_WEAR);
      bus(0, `A_CNT, 0);
      chk("wear count", got[7:0], 0);
      regs(8'h2, 0);
      cmd(`OP_SETMUL);
      bus(0, `A_MODE, 0);
      chk("multiple", {got[15:8], got[4]}, 9'h005);
      n = reqs;
      regs(1, LAST);
      cmd(8'h70);
      sense(`E_ADDR);
      regs(1, 5);
      cmd(8'h7F);
      sense(`E_NONE);
      chk("seek media", reqs, n);
      $display("power and mode test done");
   endtask
   task automatic t_write;
      int n;
      wsec(`OP_WR, 1, 3, 1, 256);
      chk("wr", {ops[1:0], last_ne, last_lba}, {`M_WR, 1'b0, 28'h3});
      wsec(`OP_WRNE, 1, 4, 1, 256);
      chk("noerase", last_ne, 1);
      wsec(`OP_WRV, 1, 5, 1, 256);
      chk("verify seq", ops[3:0], {`M_WR, `M_VFY});
      fail_op <= `M_VFY;
      wsec(`OP_WRV, 1, 5, 1, 256);
      sense(`E_ECC);
      fail_op <= `M_WR;
      wsec(`OP_WR, 1, 5, 1, 256);
      sense(`E_SPARE);
      fail_op <= 2'h0;
      // One word short of a long sector must still leave the card waiting for data
      regs(1, 6);
      cmd(`OP_WRL);
      wait_st(2'b10);
      for (int i = 0; i < 257; i++) bus(1, `A_DATA, 32'(i));
      bus(0, `A_STAT, 0);
      chk("long drq", got[1:0], 2'b10);
      bus(1, `A_DATA, 0);
      wait_st(2'b00);
      sense(`E_NONE);
      wsec(`OP_WR, 2, LAST - 28'h1, 1, 256);
      sense(`E_OVF);
      regs(1, 8);
      cmd(`OP_WR);
      wait_st(2'b10);
      bus(1, `A_CTRL, 2);
      sense(`E_XFER);
      n = irqs;
      wsec(`OP_WRM, 2, 10, 2, 256);
      chk("block irqs", irqs - n, 1);
      n = irqs;
      wsec(`OP_WRMNE, 2, 12, 2, 256);
      chk("block irqs ne", {31'(irqs - n), last_ne}, {31'h1, 1'b1});
      n = reqs;
      wsec(`OP_WRBUF, 1, 0, 1, 256);
      chk("buffer no media", reqs, n);
      rsec(`OP_RDBUF, 0);
      chk("buffer word", wbuf[9], 16'h0009);
      rsec(`OP_RD, 7);
      chk("read op", {ops[1:0], last_lba}, {`M_RD, 28'h7});
      chk("read data", wbuf[3], {8'h07 ^ 8'hA5, 8'h06 ^ 8'hA5});
      // Media side read port still points at the last fetched byte
      chk("media rdata", mrd, 8'hFF ^ 8'hA5);
      $display("sector transfer test done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clock_i);
      srst_i <= 1'b0;
      t_sense;
      t_power;
      t_write;
      results;
   end
   // About twelve thousand cycles expected, cut off well above
   initial begin
      #900000;
      num_errors++;
      results;
   end
endmodule
`default_nettype wire
